// File: verification/odt_scan_model.sv
`timescale 1ns/1ps
`default_nettype none
module odt_scan_model
  import odt_pkg::*;
(
  input  wire logic      clk_i,
  output odt_exec_req_t  exec_req_o,
  output logic           exec_o,
  input  wire logic      exec_ack_i
);
  // idle at time zero
  initial begin
    exec_o = 1'b0;
    exec_req_o = '0;
  end

  // one rung execution after gap idle cycles; the caller keeps gaps within 2.5 s
  task automatic run(input int gap, input logic [ELEM_W-1:0] e, input logic r,
                     output logic ack);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    exec_o <= 1'b1;
    exec_req_o <= '{elem: e, rung: r};
    @(posedge clk_i);
    exec_o <= 1'b0;
    exec_req_o <= '{elem: ~e, rung: ~r}; // stale request is scrambled
    @(posedge clk_i);
    ack = exec_ack_i;
  endtask
endmodule
`default_nettype wire

// File: verification/odt_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module odt_timer_monitor
  import odt_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              clk_en_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic              reg_re_i,
  input wire logic [WORD_W-1:0] reg_rdata_o,
  input wire logic              exec_i,
  input wire odt_exec_req_t     exec_req_i,
  input wire logic              exec_ack_o,
  input wire odt_exec_rsp_t     exec_rsp_o,
  input wire logic              fault_o,
  input wire logic              fault_clr_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // an execution request taken at this edge, and one aimed at a real element
  logic tk;
  logic tkv;
  assign tk = exec_i && clk_en_i;
  assign tkv = tk && (exec_req_i.elem < ELEM_W'(NUM_ELEM));

  // scan handshake and response holding
  property p_ack; tk |=> exec_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("exec not acknowledged");
  property p_elem; tk |=> exec_rsp_o.elem == $past(exec_req_i.elem); endproperty
  a_elem: assert property (p_elem) else $error("response element wrong");
  property p_hold; !tk |=> $stable(exec_rsp_o); endproperty
  a_hold: assert property (p_hold) else $error("response moved without exec");
  // status flags against the rung state
  property p_rung0; tkv && !exec_req_i.rung |=> fault_o
    || !(exec_rsp_o.enable || exec_rsp_o.timing || exec_rsp_o.done); endproperty
  a_rung0: assert property (p_rung0) else $error("flags kept after rung false");
  property p_rung1; tkv && exec_req_i.rung |=> fault_o || exec_rsp_o.enable; endproperty
  a_rung1: assert property (p_rung1) else $error("enable not set");
  property p_excl; exec_ack_o && !fault_o |-> !(exec_rsp_o.timing && exec_rsp_o.done); endproperty
  a_excl: assert property (p_excl) else $error("timing and done together");
  // register read port
  property p_idle; clk_en_i && !reg_re_i |=> reg_rdata_o == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data without strobe");
  property p_unmap; clk_en_i && reg_re_i && reg_addr_i[1:0] == 2'h3
    |=> reg_rdata_o == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped word read nonzero");
  // runtime error flag
  property p_sticky; fault_o && !fault_clr_i |=> fault_o; endproperty
  a_sticky: assert property (p_sticky) else $error("fault dropped");
  property p_clr; fault_clr_i && clk_en_i && !tk |=> !fault_o; endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");
endmodule

bind odt_timer odt_timer_monitor #(.TICK_LEN(TICK_LEN)) u_mon (
  .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .exec_i(exec_i), .exec_req_i(exec_req_i), .exec_ack_o(exec_ack_o),
  .exec_rsp_o(exec_rsp_o), .fault_o(fault_o), .fault_clr_i(fault_clr_i)
);
`default_nettype wire

// File: verification/odt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odt_timer_tb;
  import odt_pkg::*;
  localparam int unsigned TL = 4;  // short tick for simulation
  logic                 clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 clk_en_i = 1'b1;
  logic [ADDR_W-1:0]    reg_addr_i = '0;
  logic [ADDR_W-1:0]    bit_addr_i = '0;
  logic [WORD_W-1:0]    reg_wdata_i = '0;
  logic [WORD_W-1:0]    reg_rdata_o;
  logic                 reg_we_i = 1'b0;
  logic                 reg_re_i = 1'b0;
  logic                 bit_we_i = 1'b0;
  logic                 bit_val_i = 1'b0;
  logic                 fault_clr_i = 1'b0;
  logic [BIT_IDX_W-1:0] bit_idx_i = '0;
  logic                 exec_i;
  logic                 exec_ack_o;
  logic                 fault_o;
  logic [ELEM_W-1:0]    fault_elem_o;
  odt_exec_req_t        exec_req_i;
  odt_exec_rsp_t        exec_rsp_o;
  int                   mismatches = 0;
  int                   comparisons = 0;
  int                   cycles = 0;
  int                   last = 0;
  logic                 ack;

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  odt_timer #(.TICK_LEN(TL)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .bit_we_i(bit_we_i),
    .bit_addr_i(bit_addr_i), .bit_idx_i(bit_idx_i), .bit_val_i(bit_val_i),
    .exec_i(exec_i), .exec_req_i(exec_req_i), .exec_ack_o(exec_ack_o),
    .exec_rsp_o(exec_rsp_o), .fault_o(fault_o), .fault_elem_o(fault_elem_o),
    .fault_clr_i(fault_clr_i)
  );
  odt_scan_model u_scan (
    .clk_i(clk_i), .exec_req_o(exec_req_i), .exec_o(exec_i), .exec_ack_i(exec_ack_o)
  );

  // cycle count off the sampling edge, also the hang limit
  always @(negedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t value %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // word address of an element
  function automatic logic [ADDR_W-1:0] ad(input int e, input int w);
    return {e[5:0], w[1:0]};
  endfunction

  // register bus cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(posedge clk_i);
    check(reg_rdata_o, exp);
  endtask

  task automatic bw(input logic [ADDR_W-1:0] a, input logic [3:0] b, input logic v);
    @(posedge clk_i);
    bit_we_i <= 1'b1;
    bit_addr_i <= a;
    bit_idx_i <= b;
    bit_val_i <= v;
    @(posedge clk_i);
    bit_we_i <= 1'b0;
  endtask

  // execute n ticks after the previous execution, compare ack, element and flags
  task automatic sc(input int n, input int e, input logic r, input logic [2:0] f);
    int g;
    g = (n > 0) ? last + n * TL - cycles - 2 : 0;
    last = cycles + g + 2;
    u_scan.run(g, e[5:0], r, ack);
    check({6'h00, ack, exec_rsp_o}, {6'h00, 1'b1, e[5:0], f});
  endtask

  task automatic t_regs();
    rc(ad(0, 0), 16'h0000);
    rc(ad(39, 2), 16'h0000);
    wr(ad(39, 1), 16'h7fff);
    wr(ad(39, 2), 16'h1234);
    rc(ad(39, 1), 16'h7fff);
    bw(ad(39, 2), 4'h0, 1'b1);
    rc(ad(39, 2), 16'h1235);
    wr(ad(40, 1), 16'h00aa);
    wr(ad(39, 3), 16'h00aa);
    rc(ad(40, 1), 16'h0000);
    rc(ad(39, 3), 16'h0000);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    wr(ad(38, 1), 16'h0055);
    clk_en_i <= 1'b1;
    rc(ad(38, 1), 16'h0000);
  endtask

  task automatic t_count();
    wr(ad(1, 1), 16'h0005);
    sc(0, 1, 1'b1, 3'b110);
    rc(ad(1, 0), 16'hc000);
    sc(3, 1, 1'b1, 3'b110);
    rc(ad(1, 2), 16'h0003);
    sc(4, 1, 1'b1, 3'b101);
    rc(ad(1, 2), 16'h0005);
    rc(ad(1, 0), 16'ha000);
    sc(0, 1, 1'b0, 3'b000);
    rc(ad(1, 2), 16'h0000);
  endtask

  task automatic t_slow();
    wr(ad(2, 1), 16'h000a);
    wr(ad(2, 0), 16'h0001);
    sc(0, 2, 1'b1, 3'b110);
    for (int i = 0; i < 3; i++) begin
      sc(75, 2, 1'b1, 3'b110);
      rc(ad(2, 2), i[15:0]);
    end
    wr(ad(4, 1), 16'h012c);
    sc(0, 4, 1'b1, 3'b110);
    sc(250, 4, 1'b1, 3'b110);
    rc(ad(4, 2), 16'h00fa);
  endtask

  task automatic t_fault();
    wr(ad(3, 1), 16'h7fff);
    sc(0, 3, 1'b1, 3'b110);
    check({15'h0000, fault_o}, 16'h0000);
    sc(0, 40, 1'b1, 3'b000);
    for (int w = 1; w < 3; w++) begin
      wr(ad(5, w), 16'h8000);
      sc(0, 5, 1'b1, 3'b000);
      check({9'h000, fault_o, fault_elem_o}, 16'h0045);
      wr(ad(5, w), 16'h0000);
      @(posedge clk_i);
      fault_clr_i <= 1'b1;
      @(posedge clk_i);
      fault_clr_i <= 1'b0;
      @(posedge clk_i);
      check({15'h0000, fault_o}, 16'h0000);
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_count();
    t_slow();
    t_fault();
    end_sim();
  end
endmodule
`default_nettype wire

// File: verilog/odt_pkg.sv
package odt_pkg;

  // ----------------------------------------------------------------
  // element layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_ELEM     = 40;     // elements 0..39
  localparam int unsigned ELEM_W       = 6;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned ADDR_W       = 8;      // {element, word}
  localparam int unsigned BIT_IDX_W    = 4;

  // word index inside an element (address bits [1:0])
  localparam logic [1:0]  OFS_CONTROL  = 2'h0;   // timer_control_word
  localparam logic [1:0]  OFS_PRESET   = 2'h1;   // timer_preset_word
  localparam logic [1:0]  OFS_ACCUM    = 2'h2;   // timer_accumulator_word

  // control word field positions, and the sign bit of preset and count
  localparam int unsigned BIT_ENABLE   = 15;
  localparam int unsigned BIT_TIMING   = 14;
  localparam int unsigned BIT_DONE     = 13;
  localparam int unsigned BIT_TBASE    = 0;      // 1 = one-second timebase
  localparam int unsigned BIT_SIGN     = 15;     // sign of preset / count

  // reset values
  localparam logic [15:0] RST_CONTROL  = 16'h0000;
  localparam logic [15:0] RST_PRESET   = 16'h0000;
  localparam logic [15:0] RST_ACCUM    = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned TICK_MS      = 10;     // base timebase interval
  localparam int unsigned TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  localparam int unsigned TICKS_PER_S  = 100;    // 10 ms ticks in one second
  localparam int unsigned MAX_SKIP_MS  = 2500;   // longest safe gap between executions
  localparam int unsigned STAMP_W      = 8;      // holds MAX_SKIP_MS / TICK_MS ticks
  localparam int unsigned FRAC_W       = 7;      // hundredths of a second
  localparam int unsigned TICK_CNT_W   = 21;

  // ----------------------------------------------------------------
  // scan engine carriers and the count advance result
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ELEM_W-1:0] elem;
    logic              rung;
  } odt_exec_req_t;

  typedef struct packed {
    logic [ELEM_W-1:0] elem;
    logic              enable;
    logic              timing;
    logic              done;
  } odt_exec_rsp_t;

  typedef struct packed {
    logic [WORD_W-1:0] accum;
    logic [FRAC_W-1:0] frac;
  } odt_adv_t;

endpackage

// File: verilog/odt_timer.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - each timer holds control, preset, count words
// - enable bit 15, timing 14, done 13
// - count tracks elapsed time while enabled
// - done set when count reaches preset
// - preset and count range 0 to 32767
// - negative preset or count raises runtime error
// - timebase selectable 10 ms or 1 s
// - accuracy minus 10 ms, plus zero
// - one-second base accurate within 2.5 s gaps
// - skips up to 2.5 s lose no time
// - elements 0..39, word and bit access
// - counting begins when rung becomes true
// - count advances each scan until preset
// - rung false clears the count
// - rung false clears the done flag
// - enable flag follows the rung
// - timing flag while rung true, below preset

module odt_timer
  import odt_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              clk_en_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [WORD_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [WORD_W-1:0] reg_rdata_o,
  // single bit write port
  input  wire logic              bit_we_i,
  input  wire logic [ADDR_W-1:0] bit_addr_i,
  input  wire logic [BIT_IDX_W-1:0] bit_idx_i,
  input  wire logic              bit_val_i,
  // scan engine
  input  wire logic              exec_i,
  input  wire odt_exec_req_t     exec_req_i,
  output logic                   exec_ack_o,
  output odt_exec_rsp_t          exec_rsp_o,
  // runtime error
  output logic                   fault_o,
  output logic      [ELEM_W-1:0] fault_elem_o,
  input  wire logic              fault_clr_i
);

  // ----------------------------------------------------------------
  // element storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]  ctl_mem_ff   [NUM_ELEM];
  logic [WORD_W-1:0]  pre_mem_ff   [NUM_ELEM];
  logic [WORD_W-1:0]  acc_mem_ff   [NUM_ELEM];
  logic [STAMP_W-1:0] stamp_mem_ff [NUM_ELEM];
  logic [FRAC_W-1:0]  frac_mem_ff  [NUM_ELEM];

  logic [TICK_CNT_W-1:0] tick_cnt_ff;
  logic [STAMP_W-1:0]    now_ff;
  logic [WORD_W-1:0]     rdata_ff;
  logic                  ack_ff;
  odt_exec_rsp_t         rsp_ff;
  logic                  fault_ff;
  logic [ELEM_W-1:0]     fault_elem_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // element number valid and word index mapped
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:2] < ELEM_W'(NUM_ELEM)) && (a[1:0] != 2'h3);
  endfunction

  // strobe aimed at one given word of an element
  function automatic logic word_hit(input logic              ok,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [1:0]        ofs);
    return ok && (a[1:0] == ofs);
  endfunction

  // advance the count by whole intervals elapsed, saturating at preset
  function automatic odt_adv_t advance(input logic [WORD_W-1:0]  acc,
                                       input logic [WORD_W-1:0]  pre,
                                       input logic [FRAC_W-1:0]  frac,
                                       input logic [STAMP_W-1:0] elapsed,
                                       input logic               tb_sec);
    odt_adv_t    r;
    logic [16:0] sum;
    logic [8:0]  f;
    logic [1:0]  secs;
    r    = '0;
    sum  = '0;
    f    = 9'(frac) + 9'(elapsed);
    secs = 2'h0;
    if (tb_sec) begin
      // whole seconds out of the hundredths gathered so far
      // leftover hundredths carry to the next scan, so no time is lost
      for (int i = 0; i < 3; i++) begin
        if (f >= 9'(TICKS_PER_S)) begin
          f    = f - 9'(TICKS_PER_S);
          secs = secs + 2'h1;
        end
      end
      sum    = 17'(acc) + 17'(secs);
      r.frac = f[FRAC_W-1:0];                            // remainder kept
    end else begin
      sum    = 17'(acc) + 17'(elapsed);
      r.frac = '0;
    end
    // saturate at preset
    if (sum >= 17'(pre)) begin
      r.accum = pre;
      r.frac  = '0;
    end else begin
      r.accum = sum[WORD_W-1:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // timebase tick
  // ----------------------------------------------------------------
  // free 10 ms stamp; 8 bits cover the longest allowed gap
  // a gap past 255 ticks wraps and its time is lost unnoticed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_ff <= '0;
      now_ff      <= '0;
    end else if (clk_en_i) begin
      if (tick_cnt_ff == TICK_CNT_W'(TICK_LEN - 1)) begin
        tick_cnt_ff <= '0;
        now_ff      <= now_ff + 8'h01;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 21'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // execution decode
  // ----------------------------------------------------------------
  logic [ELEM_W-1:0]  ex_e;
  logic [ELEM_W-1:0]  ex_idx;
  logic               ex_ok;
  logic [FRAC_W-1:0]  ex_frac;
  logic [WORD_W-1:0]  ex_ctl;
  logic [WORD_W-1:0]  ex_pre;
  logic [WORD_W-1:0]  ex_acc;
  logic               ex_neg;
  logic [STAMP_W-1:0] ex_elapsed;
  logic               ex_was_on;
  odt_adv_t           ex_adv;
  logic [WORD_W-1:0]  nxt_acc;
  logic [FRAC_W-1:0]  nxt_frac;
  logic [WORD_W-1:0]  nxt_ctl;
  logic               nxt_done;
  logic               nxt_timing;

  assign ex_e  = exec_req_i.elem;
  assign ex_ok = exec_i && (ex_e < ELEM_W'(NUM_ELEM));

  // out-of-range requests look at element zero and write nothing back
  assign ex_idx = ex_ok ? ex_e : '0;

  // compute the new element state for the executing timer
  always_comb begin
    ex_ctl     = ctl_mem_ff[ex_idx];
    ex_pre     = pre_mem_ff[ex_idx];
    ex_acc     = acc_mem_ff[ex_idx];
    ex_frac    = frac_mem_ff[ex_idx];
    ex_neg     = ex_pre[BIT_SIGN] || ex_acc[BIT_SIGN];
    ex_was_on  = ex_ctl[BIT_ENABLE];
    ex_elapsed = now_ff - stamp_mem_ff[ex_idx];
    ex_adv     = advance(ex_acc, ex_pre, ex_frac,
                         ex_elapsed, ex_ctl[BIT_TBASE]);
    nxt_ctl    = ex_ctl;
    nxt_acc    = ex_acc;
    nxt_frac   = ex_frac;
    if (!exec_req_i.rung) begin
      // rung false: count and status cleared
      nxt_acc  = '0;
      nxt_frac = '0;
    end else if (!ex_was_on) begin
      // rising rung: start counting from now, nothing elapsed yet
      nxt_frac = '0;
    end else begin
      nxt_acc  = ex_adv.accum;
      nxt_frac = ex_adv.frac;
    end
    nxt_done   = exec_req_i.rung && (nxt_acc >= ex_pre);
    nxt_timing = exec_req_i.rung && (nxt_acc < ex_pre);
    nxt_ctl[BIT_ENABLE] = exec_req_i.rung;
    nxt_ctl[BIT_TIMING] = nxt_timing;
    nxt_ctl[BIT_DONE]   = nxt_done;
  end

  // ----------------------------------------------------------------
  // software access decode
  // ----------------------------------------------------------------
  logic [ELEM_W-1:0] wr_e;
  logic [ELEM_W-1:0] bw_e;
  logic              wr_ok;
  logic              bw_ok;

  assign wr_e  = reg_addr_i[ADDR_W-1:2];
  assign bw_e  = bit_addr_i[ADDR_W-1:2];
  assign wr_ok = reg_we_i && addr_ok(reg_addr_i);
  assign bw_ok = bit_we_i && addr_ok(bit_addr_i);

  // ----------------------------------------------------------------
  // element memory update
  // ----------------------------------------------------------------
  // in the control and count words software goes first and execution last, so the scan
  // result wins a clash; a negative operand leaves the element alone
  logic ex_upd;

  assign ex_upd = ex_ok && !ex_neg;

  // control word: whole word, single bit, then the new status
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_ELEM; i++) begin
        ctl_mem_ff[i] <= RST_CONTROL;
      end
    end else if (clk_en_i) begin
      if (word_hit(wr_ok, reg_addr_i, OFS_CONTROL)) begin
        ctl_mem_ff[wr_e] <= reg_wdata_i;
      end
      if (word_hit(bw_ok, bit_addr_i, OFS_CONTROL)) begin
        ctl_mem_ff[bw_e][bit_idx_i] <= bit_val_i;
      end
      if (ex_upd) begin
        ctl_mem_ff[ex_e] <= nxt_ctl;
      end
    end
  end

  // preset word; execution never changes it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_ELEM; i++) begin
        pre_mem_ff[i] <= RST_PRESET;
      end
    end else if (clk_en_i) begin
      if (word_hit(wr_ok, reg_addr_i, OFS_PRESET)) begin
        pre_mem_ff[wr_e] <= reg_wdata_i;
      end
      if (word_hit(bw_ok, bit_addr_i, OFS_PRESET)) begin
        pre_mem_ff[bw_e][bit_idx_i] <= bit_val_i;
      end
    end
  end

  // accumulator: whole word, single bit, then the advanced count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_ELEM; i++) begin
        acc_mem_ff[i] <= RST_ACCUM;
      end
    end else if (clk_en_i) begin
      if (word_hit(wr_ok, reg_addr_i, OFS_ACCUM)) begin
        acc_mem_ff[wr_e] <= reg_wdata_i;
      end
      if (word_hit(bw_ok, bit_addr_i, OFS_ACCUM)) begin
        acc_mem_ff[bw_e][bit_idx_i] <= bit_val_i;
      end
      if (ex_upd) begin
        acc_mem_ff[ex_e] <= nxt_acc;
      end
    end
  end

  // stamp and leftover hundredths of the last execution
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_ELEM; i++) begin
        stamp_mem_ff[i] <= '0;
        frac_mem_ff[i]  <= '0;
      end
    end else if (clk_en_i) begin
      if (ex_upd) begin
        stamp_mem_ff[ex_e] <= now_ff;
        frac_mem_ff[ex_e]  <= nxt_frac;
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data valid the cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else if (clk_en_i) begin
      if (reg_re_i && addr_ok(reg_addr_i)) begin
        case (reg_addr_i[1:0])
          OFS_CONTROL: begin
            rdata_ff <= ctl_mem_ff[reg_addr_i[ADDR_W-1:2]];
          end
          OFS_PRESET: begin
            rdata_ff <= pre_mem_ff[reg_addr_i[ADDR_W-1:2]];
          end
          OFS_ACCUM: begin
            rdata_ff <= acc_mem_ff[reg_addr_i[ADDR_W-1:2]];
          end
          default: begin
            rdata_ff <= '0;
          end
        endcase
      end else begin
        rdata_ff <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // scan engine answer
  // ----------------------------------------------------------------
  // one-cycle acknowledge with the new status of the element
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_ff <= 1'b0;
      rsp_ff <= '0;
    end else if (clk_en_i) begin
      ack_ff <= exec_i;
      if (ex_ok) begin
        rsp_ff.elem   <= ex_e;
        rsp_ff.enable <= ex_neg ? ex_ctl[BIT_ENABLE] : nxt_ctl[BIT_ENABLE];
        rsp_ff.timing <= ex_neg ? ex_ctl[BIT_TIMING] : nxt_timing;
        rsp_ff.done   <= ex_neg ? ex_ctl[BIT_DONE]   : nxt_done;
      end else if (exec_i) begin
        // no such element: flags stay low
        rsp_ff.elem   <= ex_e;
        rsp_ff.enable <= 1'h0;
        rsp_ff.timing <= 1'h0;
        rsp_ff.done   <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // runtime error
  // ----------------------------------------------------------------
  // sticky; a new error in the clear cycle wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_ff      <= 1'b0;
      fault_elem_ff <= '0;
    end else if (clk_en_i) begin
      if (ex_ok && ex_neg) begin
        fault_ff      <= 1'b1;
        fault_elem_ff <= ex_e;
      end else if (fault_clr_i) begin
        fault_ff      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o  = rdata_ff;
  assign exec_ack_o   = ack_ff;
  assign exec_rsp_o   = rsp_ff;
  assign fault_o      = fault_ff;
  assign fault_elem_o = fault_elem_ff;

endmodule
`default_nettype wire
